// ===== rtl/dma_chan_pkg.sv
// shared constants and types of the dma channel count and control block
`default_nettype none
package dma_chan_pkg;
  localparam int NUM_CH = 4;
  localparam int NUM_EXT_CH = 2;
  localparam int NUM_PERIPH = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // register map: count at index 2*ch, control at index 2*ch+1
  localparam logic [ADDR_W-1:0] REG_COUNT_BASE = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL_BASE = 4'h1;
  localparam int REG_STRIDE = 2;
  localparam logic [ADDR_W-1:0] REG_LAST_IDX = 4'h7;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 16'h0000;
  // control field positions
  localparam int DST_STEP_POS = 14;
  localparam int SRC_STEP_POS = 12;
  localparam int REQ_SRC_POS = 8;
  localparam int ACK_CYCLE_POS = 7;
  localparam int ACK_POL_POS = 6;
  localparam int DETECT_POS = 5;
  localparam int BUS_MODE_POS = 4;
  localparam int UNIT_SIZE_POS = 3;
  localparam int IRQ_EN_POS = 2;
  localparam int END_FLAG_POS = 1;
  localparam int ENABLE_POS = 0;
  localparam logic [DATA_W-1:0] LOW_CH_ONLY_MASK = 16'h00e0;
  // step codes
  localparam logic [1:0] STEP_FIXED = 2'h0;
  localparam logic [1:0] STEP_INC = 2'h1;
  localparam logic [1:0] STEP_DEC = 2'h2;
  localparam logic [1:0] STEP_RSVD = 2'h3;
  // request source codes
  localparam logic [3:0] REQ_EXT_DUAL = 4'h0;
  localparam logic [3:0] REQ_RSVD1 = 4'h1;
  localparam logic [3:0] REQ_EXT_SGL_M2D = 4'h2;
  localparam logic [3:0] REQ_EXT_SGL_D2M = 4'h3;
  localparam logic [3:0] REQ_PERIPH_FIRST = 4'h4;
  localparam logic [3:0] REQ_PERIPH_LAST = 4'hb;
  localparam logic [3:0] REQ_AUTO = 4'hc;
  localparam logic [DATA_W-1:0] COUNT_LAST = 16'h0001;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;
  // description of the bus cycle the engine is running
  typedef struct packed {
    logic active;
    logic [1:0] channel;
    logic write_phase;
    logic single_addr;
    logic word_unit;
    logic [2:0] src_step;
    logic [2:0] dst_step;
  } bus_cycle_t;
  typedef enum logic [1:0] {st_idle, st_read, st_write, st_gap} engine_state_t;
endpackage
`default_nettype wire

// ===== rtl/dma_channel_count_and_control.sv
// four-channel dma count registers, control registers and transfer sequencer
//
// Operation
// - count of one gives one unit, all ones 65535, zero gives 65536.
// - count register reads remaining units while transferring; not reset.
// - every control field clears to zero on reset and standby.
// - destination step 00 fixed, 01 up, 10 down; 1 or 2; 11 reserved.
// - destination step ignored in single mode, memory to acknowledged device.
// - source step 00 fixed, 01 up, 10 down; 1 or 2; 11 reserved.
// - source step ignored in single mode, acknowledged device to memory.
// - request source resets to 0000; codes 0, 2, 3 pick external pin.
// - codes 4-7 serial, 8-b timer match, c auto; d-f reserved.
// - external pin request codes exist only on channels 0 and 1.
// - ack cycle bit picks read or write cycle in dual mode only.
// - channels 0 and 1 choose acknowledge polarity; bit resets to zero.
// - bits 7 to 5 writable only on channels 0 and 1, else zero.
// - end flag readable, cleared by written 0, unchanged by written 1.
// - polarity 0 gives active high acknowledge, 1 active low.
// - end flag set on normal completion at zero count, not on abort.
// - unit size 0 byte, 1 word; sets step size and count unit.
`default_nettype none
module dma_channel_count_and_control (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_standby,
  input wire dma_chan_pkg::reg_req_t i_bus,
  output logic [dma_chan_pkg::DATA_W-1:0] o_rdata,
  input wire logic [dma_chan_pkg::NUM_EXT_CH-1:0] i_transfer_request_in_n,
  input wire logic [dma_chan_pkg::NUM_PERIPH-1:0] i_periph_req,
  input wire logic i_master_enable,
  input wire logic i_halt,
  output logic [dma_chan_pkg::NUM_EXT_CH-1:0] o_transfer_acknowledge_out,
  output dma_chan_pkg::bus_cycle_t o_cycle,
  output logic [dma_chan_pkg::NUM_CH-1:0] o_end_irq
);
  import dma_chan_pkg::*;
  logic [DATA_W-1:0] channel_ctrl_reg [NUM_CH];
  logic [DATA_W-1:0] remaining_count_reg [NUM_CH];
  engine_state_t state;
  engine_state_t next_state;
  logic [1:0] cur;
  logic [1:0] next_cur;
  logic [NUM_EXT_CH-1:0] req_prev_n;
  logic [NUM_EXT_CH-1:0] edge_pend;
  logic [NUM_CH-1:0] can_run;
  logic [NUM_CH-1:0] request;
  logic [DATA_W-1:0] cur_ctrl;
  logic unit_done;
  logic last_unit;
  logic start;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // a configuration the engine can legally run
  function automatic logic config_legal(input int ch, input logic [DATA_W-1:0] c);
    logic [3:0] rs;
    logic ok;
    rs = c[REQ_SRC_POS +: 4];
    ok = 1'b1;
    if (rs == REQ_RSVD1 || rs > REQ_AUTO)
      ok = 1'b0;
    // no pin source above channel 1
    if (ch >= NUM_EXT_CH && rs <= REQ_EXT_SGL_D2M)
      ok = 1'b0;
    // reserved destination step tolerated when ignored
    if (c[DST_STEP_POS +: 2] == STEP_RSVD && rs != REQ_EXT_SGL_M2D)
      ok = 1'b0;
    // reserved source step tolerated when ignored
    if (c[SRC_STEP_POS +: 2] == STEP_RSVD && rs != REQ_EXT_SGL_D2M)
      ok = 1'b0;
    return ok;
  endfunction

  // single address mode decode
  function automatic logic is_single(input logic [DATA_W-1:0] c);
    return c[REQ_SRC_POS +: 4] == REQ_EXT_SGL_M2D || c[REQ_SRC_POS +: 4] == REQ_EXT_SGL_D2M;
  endfunction

  // signed address step from a step code and unit size
  function automatic logic [2:0] step_val(input logic [1:0] code, input logic word);
    logic [2:0] s;
    s = 3'h0;
    case (code)
      STEP_INC: s = word ? 3'h2 : 3'h1;
      STEP_DEC: s = word ? 3'h6 : 3'h7;
      default: s = 3'h0;
    endcase
    return s;
  endfunction

  // request line picked by the source field
  function automatic logic src_request(input int ch, input logic [DATA_W-1:0] c,
                                       input logic [NUM_EXT_CH-1:0] pin_n,
                                       input logic [NUM_EXT_CH-1:0] pend,
                                       input logic [NUM_PERIPH-1:0] periph);
    logic [3:0] rs;
    logic r;
    rs = c[REQ_SRC_POS +: 4];
    r = 1'b0;
    if (rs == REQ_EXT_DUAL || rs == REQ_EXT_SGL_M2D || rs == REQ_EXT_SGL_D2M)
    begin
      if (ch < NUM_EXT_CH)
        r = c[DETECT_POS] ? pend[ch] : ~pin_n[ch];
    end
    else if (rs >= REQ_PERIPH_FIRST && rs <= REQ_PERIPH_LAST)
      r = periph[{rs[3], rs[1:0]}];
    else if (rs == REQ_AUTO)
      r = 1'b1;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request qualification

  // enable, master enable, no halt, end flag clear, legal setup
  always_comb
  begin
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      // set end flag blocks the channel
      can_run[ch] = channel_ctrl_reg[ch][ENABLE_POS] & i_master_enable & ~i_halt
                    & ~channel_ctrl_reg[ch][END_FLAG_POS]
                    & config_legal(ch, channel_ctrl_reg[ch]);
      request[ch] = can_run[ch] & src_request(ch, channel_ctrl_reg[ch],
                                              i_transfer_request_in_n, edge_pend,
                                              i_periph_req);
    end
  end

  // falling edge capture of the request pins
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      req_prev_n <= '1;
      edge_pend <= '0;
    end
    else
    begin
      req_prev_n <= i_transfer_request_in_n;
      for (int ch = 0; ch < NUM_EXT_CH; ch++)
      begin
        if (i_standby)
          edge_pend[ch] <= 1'b0;
        else if (req_prev_n[ch] & ~i_transfer_request_in_n[ch])
          edge_pend[ch] <= 1'b1; // a new edge beats the consume
        else if (start && next_cur == 2'(ch))
          edge_pend[ch] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencer

  assign cur_ctrl = channel_ctrl_reg[cur];
  // unit that takes the count from one to zero is the last
  assign last_unit = remaining_count_reg[cur] == COUNT_LAST;
  assign unit_done = can_run[cur] &&
                     ((state == st_read && is_single(cur_ctrl)) || state == st_write);

  // next state and channel, fixed priority lowest index first
  always_comb
  begin
    next_state = state;
    next_cur = cur;
    start = 1'b0;
    case (state)
      st_idle:
      begin
        for (int ch = NUM_CH - 1; ch >= 0; ch--)
        begin
          if (request[ch])
          begin
            next_cur = 2'(ch);
            start = 1'b1;
          end
        end
        if (start)
          next_state = st_read;
      end
      st_read:
      begin
        // cleared enable or halt aborts without end flag
        if (!can_run[cur])
          next_state = st_idle;
        else if (!is_single(cur_ctrl))
          next_state = st_write;
        else if (!last_unit && cur_ctrl[BUS_MODE_POS] && request[cur])
          next_state = st_read;
        else
          next_state = st_gap;
      end
      st_write:
      begin
        if (!can_run[cur])
          next_state = st_idle;
        else if (!last_unit && cur_ctrl[BUS_MODE_POS] && request[cur])
          next_state = st_read;
        else
          next_state = st_gap;
      end
      st_gap:
        next_state = st_idle;
      default:
        next_state = st_idle;
    endcase
  end

  // state registers
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= st_idle;
      cur <= 2'h0;
    end
    else if (i_standby)
    begin
      state <= st_idle;
      cur <= 2'h0;
    end
    else
    begin
      state <= next_state;
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  // software writes, standby clear, hardware end flag
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int ch = 0; ch < NUM_CH; ch++)
        channel_ctrl_reg[ch] <= CTRL_RESET;
    end
    else
    begin
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        if (i_standby)
          channel_ctrl_reg[ch] <= CTRL_RESET;
        else
        begin
          if (i_bus.wr && i_bus.addr == 4'(REG_CTRL_BASE + REG_STRIDE * ch))
          begin
            // low-channel-only bits forced to zero above channel 1
            if (ch < NUM_EXT_CH)
              channel_ctrl_reg[ch] <= i_bus.wdata;
            else
              channel_ctrl_reg[ch] <= i_bus.wdata & ~LOW_CH_ONLY_MASK;
            channel_ctrl_reg[ch][END_FLAG_POS] <= channel_ctrl_reg[ch][END_FLAG_POS]
                                                  & i_bus.wdata[END_FLAG_POS];
          end
          // normal completion sets the flag, winning over a clear
          if (unit_done && last_unit && cur == 2'(ch))
            channel_ctrl_reg[ch][END_FLAG_POS] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count registers, no reset

  // software load or per-unit decrement
  always_ff @(posedge i_clk)
  begin
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      if (i_bus.wr && i_bus.addr == 4'(REG_COUNT_BASE + REG_STRIDE * ch))
        remaining_count_reg[ch] <= i_bus.wdata;
      else if (unit_done && cur == 2'(ch))
        remaining_count_reg[ch] <= remaining_count_reg[ch] - COUNT_LAST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port

  // read data in the cycle after the strobe
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= READ_UNMAPPED;
    else if (i_bus.rd)
    begin
      if (i_bus.addr > REG_LAST_IDX)
        o_rdata <= READ_UNMAPPED;
      else if (i_bus.addr[0])
        o_rdata <= channel_ctrl_reg[i_bus.addr[2:1]];
      else
        o_rdata <= remaining_count_reg[i_bus.addr[2:1]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // cycle description, decoded from flip-flops only
  always_comb
  begin
    o_cycle = '0;
    o_cycle.active = state == st_read || state == st_write;
    o_cycle.channel = cur;
    o_cycle.write_phase = state == st_write;
    o_cycle.single_addr = is_single(cur_ctrl);
    o_cycle.word_unit = cur_ctrl[UNIT_SIZE_POS];
    o_cycle.src_step = step_val(cur_ctrl[SRC_STEP_POS +: 2], cur_ctrl[UNIT_SIZE_POS]);
    o_cycle.dst_step = step_val(cur_ctrl[DST_STEP_POS +: 2], cur_ctrl[UNIT_SIZE_POS]);
    // memory to device ignores destination step
    if (cur_ctrl[REQ_SRC_POS +: 4] == REQ_EXT_SGL_M2D)
      o_cycle.dst_step = 3'h0;
    // device to memory ignores source step
    if (cur_ctrl[REQ_SRC_POS +: 4] == REQ_EXT_SGL_D2M)
      o_cycle.src_step = 3'h0;
  end

  // acknowledge pins of channels 0 and 1
  always_comb
  begin
    for (int ch = 0; ch < NUM_EXT_CH; ch++)
    begin
      logic hit;
      hit = 1'b0;
      if (cur == 2'(ch) && o_cycle.active)
      begin
        // single mode always, dual mode by cycle bit
        if (is_single(channel_ctrl_reg[ch]))
          hit = 1'b1;
        else
          hit = channel_ctrl_reg[ch][ACK_CYCLE_POS] == (state == st_write);
      end
      o_transfer_acknowledge_out[ch] = hit ^ channel_ctrl_reg[ch][ACK_POL_POS];
    end
  end

  // end request level per channel
  always_comb
  begin
    for (int ch = 0; ch < NUM_CH; ch++)
      o_end_irq[ch] = channel_ctrl_reg[ch][IRQ_EN_POS] & channel_ctrl_reg[ch][END_FLAG_POS];
  end

endmodule
`default_nettype wire

// ===== bench/dma_chan_sva.sv
// assertion checker for the dma count and control block
`default_nettype none
module dma_chan_sva (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_standby,
  input wire dma_chan_pkg::reg_req_t i_bus,
  input wire logic [15:0] o_rdata,
  input wire logic i_master_enable,
  input wire logic i_halt,
  input wire logic [1:0] o_transfer_acknowledge_out,
  input wire dma_chan_pkg::bus_cycle_t o_cycle,
  input wire logic [3:0] o_end_irq
);
  import dma_chan_pkg::*;
  logic [1:0] am;
  logic [1:0] pol;
  logic [1:0] act;
  logic step_ok;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // shadow of ack cycle and polarity bits
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      {am, pol} <= 4'h0;
    else if (i_standby)
      {am, pol} <= 4'h0;
    else if (i_bus.wr && i_bus.addr inside {4'h1, 4'h3})
    begin
      am[i_bus.addr[1]] <= i_bus.wdata[ACK_CYCLE_POS];
      pol[i_bus.addr[1]] <= i_bus.wdata[ACK_POL_POS];
    end
  end
  // phase in which each ack is due, legal step sizes
  assign act[0] = o_cycle.active && o_cycle.channel == 2'h0
    && (o_cycle.single_addr || o_cycle.write_phase == am[0]);
  assign act[1] = o_cycle.active && o_cycle.channel == 2'h1
    && (o_cycle.single_addr || o_cycle.write_phase == am[1]);
  assign step_ok = o_cycle.word_unit
    ? (o_cycle.src_step inside {3'h0, 3'h2, 3'h6} && o_cycle.dst_step inside {3'h0, 3'h2, 3'h6})
    : (o_cycle.src_step inside {3'h0, 3'h1, 3'h7} && o_cycle.dst_step inside {3'h0, 3'h1, 3'h7});
  sequence read_ph;
    o_cycle.active && !o_cycle.write_phase && !o_cycle.single_addr;
  endsequence
  sequence write_ph;
    o_cycle.active && o_cycle.write_phase;
  endsequence
  a_ack_level: assert property (
    o_transfer_acknowledge_out == (act ^ pol)) else $error("ack level wrong");
  a_dual_order: assert property (
    read_ph ##0 (i_master_enable && !i_halt && !i_bus.wr && !i_standby) |=> write_ph)
    else $error("write phase missing");
  a_step_legal: assert property (
    o_cycle.active && !o_cycle.single_addr |-> step_ok) else $error("bad step");
  a_upper_bits_zero: assert property (
    i_bus.rd && i_bus.addr inside {4'h5, 4'h7} |=> o_rdata[7:5] == 3'h0)
    else $error("bits 7 to 5 set");
  a_reset_clear: assert property (disable iff (1'b0)
    i_rst && $past(i_rst) |-> !o_cycle.active && o_end_irq == 4'h0 && o_rdata == 16'h0000)
    else $error("reset not clear");
  a_standby_clear: assert property (
    i_standby |=> !o_cycle.active && o_end_irq == 4'h0) else $error("standby not clear");
  a_abort_idle: assert property (
    i_halt || !i_master_enable |=> !o_cycle.active) else $error("runs while stopped");
  a_upper_no_pin: assert property (
    o_cycle.active && o_cycle.channel[1] |-> !o_cycle.single_addr) else $error("pin mode");
  a_irq_cleared: assert property (
    i_bus.wr && i_bus.addr == 4'h1 && !i_bus.wdata[IRQ_EN_POS] |=> !o_end_irq[0])
    else $error("irq stays");
endmodule
bind dma_channel_count_and_control dma_chan_sva u_sva (.i_clk, .i_rst, .i_standby, .i_bus,
  .o_rdata, .i_master_enable, .i_halt, .o_transfer_acknowledge_out, .o_cycle, .o_end_irq);
`default_nettype wire

// ===== bench/ext_peripheral.sv
// external device on the channel 0 request pin
`default_nettype none
module ext_peripheral (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ack,
  input wire logic i_slow,
  output logic o_req_n,
  output logic [16:0] o_acks
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold;
  // count acknowledged units, back off when slow
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hold <= 2'h0;
      o_acks <= 17'h0;
    end
    else
    begin
      if (i_ack)
        o_acks <= o_acks + 17'h1;
      if (i_ack && i_slow)
        hold <= 2'h2;
      else if (hold != 2'h0)
        hold <= hold - 2'h1;
    end
  end
  // request low unless backing off
  assign o_req_n = hold != 2'h0;
endmodule
`default_nettype wire

// ===== bench/tb_dma_channel_count_and_control.sv
// self-checking bench for the dma count and control block
`default_nettype none
module tb_dma_channel_count_and_control;
  timeunit 1ns;
  timeprecision 1ps;
  import dma_chan_pkg::*;
  logic i_clk;
  logic i_rst;
  logic i_standby;
  reg_req_t bus;
  logic [15:0] rdata;
  logic req_n0;
  logic slow;
  logic [7:0] periph;
  logic master;
  logic halt;
  logic [1:0] ack;
  bus_cycle_t cyc;
  logic [3:0] irq;
  logic [16:0] acks;
  logic [16:0] acks_base;
  logic [8:0] shape;
  logic [15:0] bad [9] = '{16'h0001, 16'h0101, 16'h0201, 16'h0301, 16'h0d01, 16'h0e01,
    16'h0f01, 16'hcc01, 16'h3c01};
  int fail_count = 0;
  int checks = 0;
  int units = 0;
  int cycles = 0;
  int k;
  dma_channel_count_and_control dut (.i_clk, .i_rst, .i_standby, .i_bus(bus),
    .o_rdata(rdata), .i_transfer_request_in_n({1'b1, req_n0}), .i_periph_req(periph),
    .i_master_enable(master), .i_halt(halt), .o_transfer_acknowledge_out(ack),
    .o_cycle(cyc), .o_end_irq(irq));
  ext_peripheral peer (.i_clk, .i_rst, .i_ack(ack[0]), .i_slow(slow), .o_req_n(req_n0),
    .o_acks(acks));
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // finished units and hang guard
  always @(posedge i_clk)
  begin
    cycles++;
    if (cyc.active && (cyc.single_addr || cyc.write_phase))
      units++;
    // last channel, unit size and steps seen on the cycle output
    if (cyc.active)
      shape = {cyc.channel, cyc.word_unit, cyc.src_step, cyc.dst_step};
    if (cycles > 90000)
    begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(string name, logic [16:0] seen, logic [16:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge i_clk);
    bus <= '0;
    @(posedge i_clk);
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] exp);
    bus <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge i_clk);
    bus <= '0;
    #1 check("rdata", {1'b0, rdata}, {1'b0, exp});
    @(posedge i_clk);
  endtask
  // program a channel, run it, check units, flag, count, then clear
  task automatic run(int ch, logic [15:0] cnt, logic [15:0] ctl, logic [16:0] exp);
    logic [15:0] m;
    logic [3:0] a;
    int n;
    m = (ch > 1) ? ~LOW_CH_ONLY_MASK : 16'hffff;
    a = 4'(2 * ch);
    units = 0;
    wr(a, cnt);
    wr(a + 4'h1, (ctl | 16'h0004) & ~16'h0001);
    wr(a + 4'h1, ctl | 16'h0004);
    for (n = 0; n < (exp != 0 ? 70000 : 20) && irq[ch] !== 1'b1; n++)
      @(posedge i_clk);
    check("units", units[16:0], exp);
    rd(a + 4'h1, (ctl & m) | (exp != 0 ? 16'h0006 : 16'h0004));
    rd(a, exp != 0 ? 16'h0000 : cnt);
    if (exp != 0)
    begin
      units = 0;
      wr(a + 4'h1, ctl | 16'h0006);
      rd(a + 4'h1, (ctl & m) | 16'h0006);
      repeat (10) @(posedge i_clk);
      check("units", units[16:0], 17'h0);
    end
    wr(a + 4'h1, ctl & ~16'h0001);
    wr(a + 4'h1, 16'h0000);
    rd(a + 4'h1, 16'h0000);
  endtask
  initial
  begin
    i_rst = 1'b1;
    i_standby = 1'b0;
    bus = '0;
    slow = 1'b0;
    periph = 8'h00;
    master = 1'b1;
    halt = 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    for (k = 0; k < 4; k++)
      rd(4'(2 * k + 1), 16'h0000);
    wr(4'h5, 16'h00e0);
    rd(4'h5, 16'h0000);
    wr(4'h1, 16'h00e0);
    rd(4'h1, 16'h00e0);
    i_standby <= 1'b1;
    @(posedge i_clk);
    i_standby <= 1'b0;
    rd(4'h1, 16'h0000);
    wr(4'h8, 16'hffff);
    rd(4'h8, 16'h0000);
    acks_base = acks;
    run(0, 16'h0000, 16'hc211, 17'h10000);
    check("acks", acks - acks_base, 17'h10000);
    check("shape", {8'h00, shape}, 17'h0);
    slow <= 1'b1;
    run(0, 16'h0001, 16'h3381, 17'h1);
    check("shape", {8'h00, shape}, 17'h0);
    run(0, 16'h0002, 16'h0081, 17'h2);
    // falling edge detection on the request pin
    run(0, 16'h0002, 16'h0221, 17'h2);
    slow <= 1'b0;
    run(0, 16'h0003, 16'h5c09, 17'h3);
    check("shape", {8'h00, shape}, 17'h052);
    run(1, 16'h0002, 16'hac41, 17'h2);
    check("shape", {8'h00, shape}, 17'h0bf);
    for (k = 0; k < 8; k++)
    begin
      periph <= ~(8'h01 << k);
      run(3, 16'h0001, {4'h0, 4'(k + 4), 8'he1}, 17'h0);
      periph <= 8'h01 << k;
      run(3, 16'h0001, {4'h0, 4'(k + 4), 8'he1}, 17'h1);
    end
    check("shape", {8'h00, shape}, 17'h180);
    periph <= 8'hff;
    foreach (bad[i])
      run(2, 16'h0001, bad[i], 17'h0);
    wr(4'h2, 16'h0005);
    wr(4'h3, 16'h0c05);
    repeat (5) @(posedge i_clk);
    halt <= 1'b1;
    repeat (8) @(posedge i_clk);
    halt <= 1'b0;
    master <= 1'b0;
    repeat (8) @(posedge i_clk);
    check("irq", {16'h0000, irq[1]}, 17'h0);
    rd(4'h3, 16'h0c05);
    master <= 1'b1;
    for (k = 0; k < 100 && irq[1] !== 1'b1; k++)
      @(posedge i_clk);
    rd(4'h3, 16'h0c07);
    rd(4'h2, 16'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
